// ==== hw/ohf_consts.svh ====
`ifndef OHF_CONSTS_SVH
`define OHF_CONSTS_SVH
`define OHF_OFS_DONE_HEAD     8'h30
`define OHF_OFS_FRAME_INTV    8'h34
`define OHF_DONE_RESET        32'h0000_0000
`define OHF_DONE_ADDR_MASK    32'hffff_fff0
`define OHF_FI_NOMINAL        14'h2edf
`define OHF_FI_LSB            0
`define OHF_FI_MSB            13
`define OHF_FS_LSB            16
`define OHF_FS_MSB            30
`define OHF_TOGGLE_BIT        31
`define OHF_INTV_WMASK        32'hffff_3fff
`endif

// ==== hw/ohf_pkg.sv ====
package ohf_pkg;
  // Register read/write request from the register access port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ohf_req_s;

  // Descriptor retirement event from the list engine
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } ohf_retire_s;

  // Link store toward memory
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] data;
  } ohf_mem_wr_s;
endpackage

// ==== hw/ohf_regs.sv ====
`timescale 1ns/1ns
`include "ohf_consts.svh"
module ohf_regs
  import ohf_pkg::*;
#(
  parameter int FI_W = 14,
  parameter int FS_W = 15
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        bit_tick,
  input  wire ohf_req_s    req,
  output logic [31:0]      rdata,
  output logic             rvalid,
  input  wire ohf_retire_s retire,
  input  wire logic        host_comm_area_post,
  input  wire logic [31:0] host_comm_area_addr,
  output ohf_mem_wr_s      mem_wr,
  output logic [FI_W-1:0]  frame_remaining_count,
  output logic             remaining_toggle_bit,
  output logic             frame_start,
  output logic [FS_W-1:0]  packet_budget
);

  // Field slices below are laid out for these widths only
  if (FI_W != 14 || FS_W != 15) begin : g_bad_width
    $error("ohf_regs: field widths are fixed by the register layout");
  end

  // Offset match shared by both register selects
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] done_queue_head_pointer;
  logic [31:0] frame_interval_config;

  // Address decode
  wire hit_done  = addr_hit(req.addr, `OHF_OFS_DONE_HEAD);
  wire hit_intv  = addr_hit(req.addr, `OHF_OFS_FRAME_INTV);
  wire wr_done   = req.wr && hit_done;
  wire wr_intv   = req.wr && hit_intv;

  // Field views
  wire [13:0] frame_length_bit_times   = frame_interval_config[`OHF_FI_MSB:`OHF_FI_LSB];
  wire [14:0] full_speed_largest_packet = frame_interval_config[`OHF_FS_MSB:`OHF_FS_LSB];
  wire        interval_toggle_bit      = frame_interval_config[`OHF_TOGGLE_BIT];
  wire [31:0] done_head_address_field  = done_queue_head_pointer & `OHF_DONE_ADDR_MASK;

  // ----------------------------------------------------------------
  // Done queue head
  // ----------------------------------------------------------------
  // Retirement beats a same-cycle post so no descriptor is lost from the queue
  wire [31:0] next_done =
      retire.valid ? (retire.addr & `OHF_DONE_ADDR_MASK) :
      host_comm_area_post    ? `OHF_DONE_RESET :
      wr_done      ? (req.wdata & `OHF_DONE_ADDR_MASK) :
                     done_queue_head_pointer;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_queue_head_pointer <= `OHF_DONE_RESET;
    end else begin
      done_queue_head_pointer <= next_done;
    end
  end

  // Memory store: link field on retirement, else head post to comm area
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_wr <= '0;
    end else begin
      mem_wr.valid <= retire.valid || host_comm_area_post;
      mem_wr.addr  <= retire.valid ? retire.addr : host_comm_area_addr;
      mem_wr.data  <= done_head_address_field;
    end
  end

  // ----------------------------------------------------------------
  // Frame interval
  // ----------------------------------------------------------------
  // Reserved bits 15..14 are forced to zero whatever software sends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_interval_config <= {18'h0, `OHF_FI_NOMINAL};
    end else if (wr_intv) begin
      frame_interval_config <= req.wdata & `OHF_INTV_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // Frame remaining counter
  // ----------------------------------------------------------------
  // Reload only from zero, so a write never shortens the running frame
  wire reload = bit_tick && (frame_remaining_count == 14'h0);
  wire [13:0] next_remaining = reload ? frame_length_bit_times :
                               frame_remaining_count - 14'h1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_remaining_count <= '0;
      remaining_toggle_bit  <= 1'b0;
      frame_start           <= 1'b0;
      packet_budget         <= '0;
    end else begin
      frame_start <= reload;
      if (bit_tick) begin
        frame_remaining_count <= next_remaining;
      end
      if (reload) begin
        remaining_toggle_bit <= interval_toggle_bit;
        packet_budget        <= full_speed_largest_packet;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] read_mux = hit_done ? done_queue_head_pointer :
                         hit_intv ? frame_interval_config : 32'h0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rdata  <= req.rd ? read_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_retire_sets_head: assert property (@(posedge clk) disable iff (!arst_n)
    retire.valid |=> done_queue_head_pointer == ($past(retire.addr) & `OHF_DONE_ADDR_MASK))
    else $error("head not updated on retire");
  a_link_stores_head: assert property (@(posedge clk) disable iff (!arst_n)
    retire.valid |=> mem_wr.valid && mem_wr.data == $past(done_head_address_field))
    else $error("link store wrong");
  a_post_clears_head: assert property (@(posedge clk) disable iff (!arst_n)
    host_comm_area_post && !retire.valid |=> done_queue_head_pointer == 32'h0)
    else $error("head not cleared on post");
  a_post_writes_area: assert property (@(posedge clk) disable iff (!arst_n)
    host_comm_area_post && !retire.valid |=> mem_wr.valid && mem_wr.addr == $past(host_comm_area_addr))
    else $error("post store missing");
  a_head_low_zero: assert property (@(posedge clk) disable iff (!arst_n)
    done_queue_head_pointer[3:0] == 4'h0)
    else $error("head reserved bits set");
  a_intv_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    frame_interval_config[15:14] == 2'b00)
    else $error("interval reserved bits set");
  a_reload_value: assert property (@(posedge clk) disable iff (!arst_n)
    reload |=> frame_remaining_count == $past(frame_length_bit_times))
    else $error("reload wrong");
  a_decrement_step: assert property (@(posedge clk) disable iff (!arst_n)
    bit_tick && !reload |=> frame_remaining_count == $past(frame_remaining_count) - 14'h1)
    else $error("decrement wrong");
  a_toggle_copy: assert property (@(posedge clk) disable iff (!arst_n)
    reload |=> remaining_toggle_bit == $past(interval_toggle_bit))
    else $error("toggle not copied");
  a_budget_load: assert property (@(posedge clk) disable iff (!arst_n)
    reload |=> frame_start && packet_budget == $past(full_speed_largest_packet))
    else $error("budget not loaded");
  a_frame_kept: assert property (@(posedge clk) disable iff (!arst_n)
    wr_intv && !reload |=> frame_remaining_count == $past(frame_remaining_count) - 14'($past(bit_tick)))
    else $error("write disturbed frame");
  a_read_head: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && hit_done |=> rvalid && rdata == $past(done_queue_head_pointer))
    else $error("head read wrong");

  // ----------------------------------------------------------------
  // Further checks on ordering, holding and reset values
  // ----------------------------------------------------------------
  // Retire and post together: the retirement must win
  a_retire_wins_post: assert property (@(posedge clk) disable iff (!arst_n)
    retire.valid && host_comm_area_post
    |=> done_queue_head_pointer == ($past(retire.addr) & `OHF_DONE_ADDR_MASK))
    else $error("retire lost to post");

  // Link store goes to the retired descriptor
  a_link_addr_retire: assert property (@(posedge clk) disable iff (!arst_n)
    retire.valid
    |=> mem_wr.addr == $past(retire.addr))
    else $error("link store address wrong");

  // Post carries the head value as it stood
  a_post_data_head: assert property (@(posedge clk) disable iff (!arst_n)
    host_comm_area_post && !retire.valid
    |=> mem_wr.data == $past(done_head_address_field))
    else $error("post data wrong");

  // No stray memory stores
  a_store_on_event: assert property (@(posedge clk) disable iff (!arst_n)
    !retire.valid && !host_comm_area_post
    |=> !mem_wr.valid)
    else $error("stray memory store");

  // Software head write lands masked when nothing else competes
  a_head_write: assert property (@(posedge clk) disable iff (!arst_n)
    wr_done && !retire.valid && !host_comm_area_post
    |=> done_queue_head_pointer == ($past(req.wdata) & `OHF_DONE_ADDR_MASK))
    else $error("head write wrong");

  // Head holds without an event, so reads see a steady value
  a_head_idle_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !retire.valid && !host_comm_area_post && !wr_done
    |=> $stable(done_queue_head_pointer))
    else $error("head changed while idle");

  // Interval write lands with reserved bits cleared
  a_intv_write: assert property (@(posedge clk) disable iff (!arst_n)
    wr_intv
    |=> frame_interval_config == ($past(req.wdata) & `OHF_INTV_WMASK))
    else $error("interval write wrong");

  // Interval holds without a write
  a_intv_idle_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_intv
    |=> $stable(frame_interval_config))
    else $error("interval changed while idle");

  // Counter moves only on a bit time
  a_count_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !bit_tick
    |=> $stable(frame_remaining_count))
    else $error("counter moved without tick");

  // Zero on a tick always starts a frame
  a_reload_at_zero: assert property (@(posedge clk) disable iff (!arst_n)
    bit_tick && frame_remaining_count == 14'h0
    |=> frame_start)
    else $error("no frame start at zero");

  // Frame start is a single pulse
  a_start_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    !reload
    |=> !frame_start)
    else $error("stray frame start");

  // Budget changes only at a frame start
  a_budget_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !reload
    |=> $stable(packet_budget))
    else $error("budget changed mid frame");

  // Remaining toggle changes only at a reload
  a_toggle_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !reload
    |=> $stable(remaining_toggle_bit))
    else $error("toggle changed mid frame");

  // Interval read returns the register
  a_read_intv: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && hit_intv
    |=> rvalid && rdata == $past(frame_interval_config))
    else $error("interval read wrong");

  // Unmapped offsets read as zero
  a_read_other: assert property (@(posedge clk) disable iff (!arst_n)
    req.rd && !hit_done && !hit_intv
    |=> rvalid && rdata == 32'h0)
    else $error("unmapped read not zero");

  // Read strobe and data last one cycle only
  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    !req.rd
    |=> !rvalid && rdata == 32'h0)
    else $error("read answer without request");

  // Reset leaves the nominal frame length
  a_fi_after_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n)
    |-> frame_length_bit_times == `OHF_FI_NOMINAL)
    else $error("frame length not nominal after reset");

  // Reset leaves the upper interval fields clear
  a_intv_upper_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n)
    |-> frame_interval_config[31:14] == 18'h0)
    else $error("interval fields not clear after reset");

  // Reset leaves the head at zero
  a_head_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n)
    |-> done_queue_head_pointer == 32'h0)
    else $error("head not zero after reset");

  // Counter and its toggle start from zero so the first tick reloads
  a_count_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n)
    |-> frame_remaining_count == 14'h0 && !remaining_toggle_bit)
    else $error("counter not zero after reset");

  // Budget and frame start are quiet out of reset
  a_budget_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n)
    |-> packet_budget == 15'h0 && !frame_start)
    else $error("budget not zero after reset");

  // No store or read answer out of reset
  a_outputs_reset: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(arst_n)
    |-> !mem_wr.valid && !rvalid)
    else $error("outputs active after reset");

endmodule

// ==== testbench/ohf_regs_tb.sv ====
`timescale 1ns/1ns
`include "ohf_consts.svh"
module ohf_regs_tb
  import ohf_pkg::*;
;
  logic        clk, arst_n, bit_tick, host_comm_area_post, rvalid, frame_start, remaining_toggle_bit;
  logic [31:0] host_comm_area_addr, rdata;
  logic [13:0] frame_remaining_count;
  logic [14:0] packet_budget;
  ohf_req_s    req;
  ohf_retire_s retire;
  ohf_mem_wr_s mem_wr;
  int          miscompares, check_count, m_cnt, m_fs, m_tog, i;
  bit   [31:0] m_head, m_intv, rs;

  ohf_regs ohf_regs_inst (.clk(clk), .arst_n(arst_n), .bit_tick(bit_tick), .req(req), .rdata(rdata),
    .rvalid(rvalid), .retire(retire), .host_comm_area_post(host_comm_area_post), .host_comm_area_addr(host_comm_area_addr), .mem_wr(mem_wr),
    .frame_remaining_count(frame_remaining_count), .remaining_toggle_bit(remaining_toggle_bit),
    .frame_start(frame_start), .packet_budget(packet_budget));

  // 20 MHz clock
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks and reference model
  // ----------------------------------------
  function automatic bit [31:0] lf(bit [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Model state follows the block's own reset
  task do_reset;
    @(posedge clk) arst_n <= 1'b0;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    m_head = `OHF_DONE_RESET;
    m_intv = {18'h0, `OHF_FI_NOMINAL};
    {m_cnt, m_fs, m_tog} = '0;
  endtask

  // Reserved bits are masked by the block, so the model masks too
  task wr(bit [7:0] a, bit [31:0] d);
    d = d & (a == `OHF_OFS_DONE_HEAD ? `OHF_DONE_ADDR_MASK : a == `OHF_OFS_FRAME_INTV ? `OHF_INTV_WMASK : 32'h0);
    @(posedge clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) req <= '0;
    if (a == `OHF_OFS_DONE_HEAD) m_head = d & `OHF_DONE_ADDR_MASK;
    if (a == `OHF_OFS_FRAME_INTV) m_intv = d & `OHF_INTV_WMASK;
  endtask

  // Each new interval flips the toggle so software can see it land
  task wi(bit [31:0] d);
    wr(`OHF_OFS_FRAME_INTV, {~m_intv[31], d[30:0]});
  endtask

  task rd(bit [7:0] a);
    @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clk) req <= '0;
    #1 chk("rvalid", 32'(rvalid), 1);
    chk("rdata", rdata, a == `OHF_OFS_DONE_HEAD ? m_head : a == `OHF_OFS_FRAME_INTV ? m_intv : 0);
  endtask

  // Retirement (p=0) or posting to host comm area (p=1)
  task mem(bit p, bit [31:0] a);
    @(posedge clk) begin
      host_comm_area_post <= p;
      host_comm_area_addr <= a;
      retire <= '{!p, a};
    end
    @(posedge clk) begin
      host_comm_area_post <= 1'b0;
      retire <= '0;
    end
    #1 chk("mem_valid", 32'(mem_wr.valid), 1);
    chk("mem_addr", mem_wr.addr, a);
    chk("mem_data", mem_wr.data, m_head);
    m_head = p ? 0 : a & `OHF_DONE_ADDR_MASK;
  endtask

  task tick;
    @(posedge clk) bit_tick <= 1'b1;
    @(posedge clk) bit_tick <= 1'b0;
    #1 chk("sof", 32'(frame_start), 32'(m_cnt == 0));
    if (m_cnt == 0) {m_cnt, m_tog, m_fs} = {int'(m_intv[13:0]), int'(m_intv[31]), int'(m_intv[30:16])};
    else m_cnt--;
    chk("count", 32'(frame_remaining_count), m_cnt);
    chk("budget", 32'(packet_budget), m_fs);
    chk("toggle", 32'(remaining_toggle_bit), m_tog);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {arst_n, bit_tick, host_comm_area_post, host_comm_area_addr, req, retire} = '0;
    rs = 32'd21897;
    do_reset();
    rd(`OHF_OFS_DONE_HEAD);
    rd(`OHF_OFS_FRAME_INTV);
    for (i = 0; i < 6; i++) begin
      rs = lf(rs);
      wi(rs);
      rd(`OHF_OFS_FRAME_INTV);
      rs = lf(rs);
      wr(`OHF_OFS_DONE_HEAD, rs);
      rd(`OHF_OFS_DONE_HEAD);
      rs = lf(rs);
      mem(1'b0, rs);
      rd(`OHF_OFS_DONE_HEAD);
      rs = lf(rs);
      mem(1'b1, rs);
      rd(`OHF_OFS_DONE_HEAD);
      wr(8'h38, rs);
      rd(8'h38);
    end
    // Short frames keep the reload visible; mid-frame rewrite must wait
    wi({1'b0, rs[14:0], 16'd6});
    for (i = 0; i < 16; i++) begin
      if (i == 3) wi({1'b0, rs[30:16], 16'd4});
      tick();
    end
    rs = m_intv;
    do_reset();
    rd(`OHF_OFS_FRAME_INTV);
    tick();
    wr(`OHF_OFS_FRAME_INTV, rs);
    rd(`OHF_OFS_FRAME_INTV);
    conclude();
  end

  // Watchdog well beyond the expected run
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule
